// File: hw/smbx_pkg.sv
// Purpose: Shared constants for the slave bus mailbox and fault block
// Assumes: 24-bit byte addresses on both the local and the shared bus
// Notes:   Constants only, no logic

package smbx_pkg;

  // ==========================================================
  // Local CPU register addresses
  localparam logic [23:0] LOC_MAILBOX_ADDR  = 24'h4E_0004;
  localparam logic [23:0] LOC_IRQ_TRIG_ADDR = 24'h4E_0006;
  localparam logic [23:0] LOC_FAULT_ADDR    = 24'h4E_0007;

  // ==========================================================
  // Shared bus window and slot register decode
  localparam logic [3:0]  ICB_WIN_NIBBLE    = 4'h6;
  localparam logic [15:0] SLOT_REG_OFFS     = 16'hFFFC;

  // ==========================================================
  // Configuration port fields
  localparam int CFG_RESET_BIT = 15;
  localparam int CFG_HALT_BIT  = 14;
  localparam int CFG_IRQ_BIT   = 13;
  localparam int CFG_PRI_HI    = 12;
  localparam int CFG_PRI_LO    = 11;
  localparam int CFG_LVL_HI    = 10;
  localparam int CFG_LVL_LO    = 8;
  localparam int CFG_CMD_HI    = 7;
  // Reset and halt released, priority 0, no bus level
  localparam logic [15:0] CFG_RESET_VAL = 16'hC000;
  localparam logic [7:0]  CMD_RESET_VAL = 8'h00;

  // ==========================================================
  // Status and identity word fields
  localparam int STAT_SI_BIT    = 15;
  localparam int STAT_MI_BIT    = 14;
  localparam int STAT_SLAVE_BIT = 8;
  // Board type code: value is arbitrary
  localparam logic [4:0] BOARD_TYPE = 5'h0A;
  localparam logic [7:0] STATUS_RESET_VAL = 8'h00;

  // ==========================================================
  // Fault cause byte fields
  localparam int FLT_TIMEOUT_BIT  = 6;
  localparam int FLT_BUS_ERR_BIT  = 5;
  localparam int FLT_UNCORR_BIT   = 4;
  localparam int FLT_CODE_DATA    = 3;
  localparam int FLT_DATA_EXEC    = 2;
  localparam int FLT_PROT_WR      = 1;
  localparam int FLT_OWNER_BIT    = 0;
  localparam logic [7:0] FAULT_RESET_VAL = 8'h00;

  // ==========================================================
  // Local interrupt levels
  localparam logic [2:0] LVL_FROM_MASTER = 3'h5;
  localparam logic [2:0] LVL_SERIAL      = 3'h4;
  localparam logic [2:0] LVL_NONE        = 3'h0;

endpackage : smbx_pkg

// File: hw/smbx_flag.sv
// Purpose: Sticky request flag, set by one party, cleared by another
// Assumes: set and clr are one-cycle pulses
// Notes:   Set wins over a clear in the same cycle

`timescale 1ns/1ps
`default_nettype none

module smbx_flag (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic set,
  input  wire logic clr,
  output logic      q
);

  // ==========================================================
  // Flag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= 1'b0;
    end else if (set) begin
      q <= 1'b1;
    end else if (clr) begin
      q <= 1'b0;
    end
  end

endmodule : smbx_flag

`default_nettype wire

// File: hw/smbx_ipl_enc.sv
// Purpose: Encode interrupt sources to a local autovector level
// Assumes: All sources are active-high levels synchronous to clk
// Notes:   Slave and master boards map bus requests differently

`timescale 1ns/1ps
`default_nettype none

module smbx_ipl_enc
  import smbx_pkg::*;
(
  input  wire logic       is_master,
  input  wire logic       from_master_irq,
  input  wire logic       serial_irq,
  input  wire logic [5:1] bus_irq,
  output logic      [2:0] ipl
);

  // ==========================================================
  // Priority encode, highest level wins
  always_comb begin
    ipl = LVL_NONE;
    if (is_master) begin
      for (int i = 1; i <= 5; i++) begin
        if (bus_irq[i]) begin
          ipl = 3'(i);
        end
      end
      // Level four shared by serial ports and bus request four
      if (serial_irq && ipl < LVL_SERIAL) begin
        ipl = LVL_SERIAL;
      end
    end else begin
      if (serial_irq) begin
        ipl = LVL_SERIAL;
      end
      if (from_master_irq) begin
        ipl = LVL_FROM_MASTER;
      end
    end
  end

endmodule : smbx_ipl_enc

`default_nettype wire

// File: hw/smbx_top.sv
// Purpose: Slave side of the inter-processor bus: mailbox, request
//          flags, fault cause latch, slot configuration and status
// Assumes: Single 125 MHz clock, all inputs synchronous, strobes are
//          one-cycle pulses, system reset drives rst
// Notes:   Answers on both buses come one cycle after the strobe

`timescale 1ns/1ps
`default_nettype none

// What this block does
// - One local address reads master command byte, writes slave status byte.
// - Master command write raises local interrupt; local mailbox read clears it.
// - Any local write to trigger address sets outgoing request; data discarded.
// - Local CPU cannot read back its outgoing request or its level.
// - Master reading the status byte clears the slave's outgoing request.
// - Fault cause byte latches flags at each bus fault, holds until next.
// - Fault bits: 6 timeout, 5 bus error, 4 uncorrectable memory; 7 unused.
// - Fault bits: 3 code page data, 2 data page execute, 1 protect, 0 owner.
// - Config word: 15 reset, 14 halt, 13 irq, 12:11 pri, 10:8 level, cmd.
// - Writing one to config irq bit interrupts the slave CPU.
// - Two priority bits set slave priority on the main memory bus.
// - Status word: 15 si, 14 mi, 13:9 board type, 8 slave, 7:0 status.
// - Status word readable as either byte or as a whole word.
// - Slot registers decode inside bus window, selected by board slot number.
// - On a slave board, master interrupt reaches CPU as level five.
// - On a master board, bus requests map to levels 1-5, four shared.
module smbx_top
  import smbx_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        is_master,
  input  wire logic [3:0]  slot_id,
  input  wire logic        loc_rd,
  input  wire logic        loc_wr,
  input  wire logic [23:0] loc_addr,
  input  wire logic [7:0]  loc_wdata,
  output logic      [7:0]  loc_rdata,
  output logic             loc_ack,
  input  wire logic        icb_rd,
  input  wire logic        icb_wr,
  input  wire logic [23:0] icb_addr,
  input  wire logic        icb_uds,
  input  wire logic        icb_lds,
  input  wire logic [15:0] icb_wdata,
  output logic      [15:0] icb_rdata,
  output logic             icb_dtack,
  input  wire logic [7:1]  icb_irq_in_n,
  output logic      [7:1]  icb_irq_o,
  output logic      [7:1]  icb_irq_oe,
  input  wire logic        fault_stb,
  input  wire logic [6:0]  fault_flags,
  input  wire logic        serial_irq,
  output logic      [2:0]  cpu_ipl,
  output logic             slave_reset_n,
  output logic             slave_halt_n,
  output logic      [1:0]  main_memory_bus_pri
);

  // ==========================================================
  // Declarations
  logic        loc_mbox_hit;
  logic        loc_trig_hit;
  logic        loc_fault_hit;
  logic        icb_hit;
  logic        icb_cfg_wr;
  logic        icb_cmd_wr;
  logic        icb_stat_rd;
  logic        in_irq_set;
  logic        in_irq_clr;
  logic        out_req_set;
  logic        out_req_clr;
  logic        slave_irq_pending;
  logic        master_irq_pending;
  logic [7:0]  cmd_byte;
  logic [7:0]  status_byte;
  logic [7:0]  fault_cause;
  logic [15:8] cfg_hi;
  logic [2:0]  out_level;
  logic [15:0] status_word;
  logic [7:0]  next_loc_rdata;
  logic        loc_mapped;
  logic [15:8] next_cfg_hi;
  logic [7:0]  next_fault_cause;
  logic [5:1]  bus_irq;

  // ==========================================================
  // Address decode
  function automatic logic slot_match(
    input logic [23:0] a,
    input logic [3:0]  slot
  );
    slot_match = (a[23:20] == ICB_WIN_NIBBLE) &&
                 (a[19:16] == slot) &&
                 (a[15:1] == SLOT_REG_OFFS[15:1]);
  endfunction : slot_match

  // Whole level decoded to one bus request line
  function automatic logic [7:1] level_onehot(input logic [2:0] lvl);
    level_onehot = '0;
    for (int i = 1; i <= 7; i++) begin
      if (lvl == 3'(i)) begin
        level_onehot[i] = 1'b1;
      end
    end
  endfunction : level_onehot

  assign loc_mbox_hit  = (loc_addr == LOC_MAILBOX_ADDR);
  assign loc_trig_hit  = (loc_addr == LOC_IRQ_TRIG_ADDR);
  assign loc_fault_hit = (loc_addr == LOC_FAULT_ADDR);
  // Unmapped local addresses get no answer at all
  assign loc_mapped    = loc_mbox_hit || loc_trig_hit || loc_fault_hit;

  // Window and slot number select this board's slot registers
  assign icb_hit     = slot_match(icb_addr, slot_id);
  assign icb_cfg_wr  = icb_wr && icb_hit && icb_uds;
  assign icb_cmd_wr  = icb_wr && icb_hit && icb_lds;
  // Status byte sits on the low lane, read alone or as a word
  assign icb_stat_rd = icb_rd && icb_hit && icb_lds;

  // ==========================================================
  // Request flags
  // Command write or config irq bit interrupts the local CPU
  assign in_irq_set = icb_cmd_wr ||
                      (icb_cfg_wr && icb_wdata[CFG_IRQ_BIT]);
  assign in_irq_clr = loc_rd && loc_mbox_hit;

  // Written data ignored, any write raises the request
  assign out_req_set = loc_wr && loc_trig_hit;
  assign out_req_clr = icb_stat_rd;

  // Both flags clear on reset and let a set win over a clear
  smbx_flag u_in_irq (
    .clk (clk),
    .rst (rst),
    .set (in_irq_set),
    .clr (in_irq_clr),
    .q   (slave_irq_pending)
  );

  smbx_flag u_out_req (
    .clk (clk),
    .rst (rst),
    .set (out_req_set),
    .clr (out_req_clr),
    .q   (master_irq_pending)
  );

  // ==========================================================
  // Mailbox bytes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_byte <= CMD_RESET_VAL;
    end else if (icb_cmd_wr) begin
      cmd_byte <= icb_wdata[CFG_CMD_HI:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_byte <= STATUS_RESET_VAL;
    end else if (loc_wr && loc_mbox_hit) begin
      status_byte <= loc_wdata;
    end
  end

  // ==========================================================
  // Configuration port, high byte
  // Irq bit is an action, not stored state
  always_comb begin
    next_cfg_hi = cfg_hi;
    if (icb_cfg_wr) begin
      next_cfg_hi = icb_wdata[15:8];
      next_cfg_hi[CFG_IRQ_BIT] = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_hi <= CFG_RESET_VAL[15:8];
    end else begin
      cfg_hi <= next_cfg_hi;
    end
  end

  // Reset and halt are active low: clear both to hold the slave
  assign slave_reset_n = cfg_hi[CFG_RESET_BIT];
  assign slave_halt_n  = cfg_hi[CFG_HALT_BIT];
  assign main_memory_bus_pri =
    cfg_hi[CFG_PRI_HI:CFG_PRI_LO];
  assign out_level = cfg_hi[CFG_LVL_HI:CFG_LVL_LO];

  // ==========================================================
  // Outgoing bus request, open-drain low drive
  // Level zero drives no line
  assign icb_irq_o  = '0;
  assign icb_irq_oe = master_irq_pending ?
                      level_onehot(out_level) : '0;

  // ==========================================================
  // Fault cause latch
  // Each cause lands on its own bit; bit 7 always reads zero
  // Source wiring must follow the same bit order as the byte
  always_comb begin
    next_fault_cause = FAULT_RESET_VAL;
    next_fault_cause[FLT_TIMEOUT_BIT] = fault_flags[FLT_TIMEOUT_BIT];
    next_fault_cause[FLT_BUS_ERR_BIT] = fault_flags[FLT_BUS_ERR_BIT];
    next_fault_cause[FLT_UNCORR_BIT]  = fault_flags[FLT_UNCORR_BIT];
    next_fault_cause[FLT_CODE_DATA]   = fault_flags[FLT_CODE_DATA];
    next_fault_cause[FLT_DATA_EXEC]   = fault_flags[FLT_DATA_EXEC];
    next_fault_cause[FLT_PROT_WR]     = fault_flags[FLT_PROT_WR];
    next_fault_cause[FLT_OWNER_BIT]   = fault_flags[FLT_OWNER_BIT];
  end

  // Whole byte replaced at each fault, held between faults
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fault_cause <= FAULT_RESET_VAL;
    end else if (fault_stb) begin
      fault_cause <= next_fault_cause;
    end
  end

  // ==========================================================
  // Local read mux
  // Trigger address reads zero so the flag and level stay hidden
  always_comb begin
    next_loc_rdata = 8'h00;
    if (loc_mbox_hit) begin
      next_loc_rdata = cmd_byte;
    end else if (loc_fault_hit) begin
      next_loc_rdata = fault_cause;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      loc_ack <= 1'b0;
    end else begin
      loc_ack <= (loc_rd || loc_wr) && loc_mapped;
    end
  end

  // Read data holds until the next local read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      loc_rdata <= 8'h00;
    end else if (loc_rd) begin
      loc_rdata <= next_loc_rdata;
    end
  end

  // ==========================================================
  // Slot status word and master read path
  // Flags read live, so a read shows them before its own clear
  always_comb begin
    status_word = '0;
    status_word[STAT_SI_BIT]    = slave_irq_pending;
    status_word[STAT_MI_BIT]    = master_irq_pending;
    status_word[STAT_MI_BIT-1:STAT_SLAVE_BIT+1] = BOARD_TYPE;
    status_word[STAT_SLAVE_BIT] = ~is_master;
    status_word[STAT_SLAVE_BIT-1:0] = status_byte;
  end

  // Only this slot answers, so other boards share the strobes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      icb_dtack <= 1'b0;
    end else begin
      icb_dtack <= (icb_rd || icb_wr) && icb_hit;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      icb_rdata <= 16'h0000;
    end else if (icb_rd && icb_hit) begin
      // Unselected lane reads zero
      icb_rdata <= status_word &
                   {{8{icb_uds}}, {8{icb_lds}}};
    end
  end

  // ==========================================================
  // Local interrupt level
  assign bus_irq = ~icb_irq_in_n[5:1];

  smbx_ipl_enc u_ipl (
    .is_master       (is_master),
    .from_master_irq (slave_irq_pending),
    .serial_irq      (serial_irq),
    .bus_irq         (bus_irq),
    .ipl             (cpu_ipl)
  );

endmodule : smbx_top

`default_nettype wire

// File: verif/smbx_top_sva.sv
// Purpose: Port assertions for the slave bus mailbox block
// Assumes: One clock, asynchronous active high reset
// Notes:   Bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module smbx_top_sva
  import smbx_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        is_master,
  input wire logic [3:0]  slot_id,
  input wire logic        loc_rd,
  input wire logic        loc_wr,
  input wire logic [23:0] loc_addr,
  input wire logic [7:0]  loc_rdata,
  input wire logic        loc_ack,
  input wire logic        icb_rd,
  input wire logic        icb_wr,
  input wire logic [23:0] icb_addr,
  input wire logic        icb_uds,
  input wire logic        icb_lds,
  input wire logic [15:0] icb_wdata,
  input wire logic [15:0] icb_rdata,
  input wire logic        icb_dtack,
  input wire logic [7:1]  icb_irq_o,
  input wire logic [7:1]  icb_irq_oe,
  input wire logic        fault_stb,
  input wire logic [6:0]  fault_flags,
  input wire logic        serial_irq,
  input wire logic [2:0]  cpu_ipl,
  input wire logic        slave_reset_n,
  input wire logic [1:0]  main_memory_bus_pri
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // ==========================================================
  // Reference copy of both request flags and the bus level
  logic       si_m, mi_m, mapped, hit;
  logic [2:0] lvl_m;
  logic [7:1] oe_m;
  assign mapped = loc_addr inside {LOC_MAILBOX_ADDR, LOC_IRQ_TRIG_ADDR,
                                   LOC_FAULT_ADDR};
  assign hit = icb_addr[23:16] == {ICB_WIN_NIBBLE, slot_id}
            && icb_addr[15:1] == SLOT_REG_OFFS[15:1];
  assign oe_m = (mi_m && lvl_m != LVL_NONE) ? 7'(1) << (lvl_m - 3'd1)
                                            : 7'h00;
  always_ff @(posedge clk or posedge rst)
    if (rst) mi_m <= 1'b0;
    else if (loc_wr && loc_addr == LOC_IRQ_TRIG_ADDR) mi_m <= 1'b1;
    else if (icb_rd && hit && icb_lds) mi_m <= 1'b0;
  // Set checked first: a set wins over a clear in one cycle
  always_ff @(posedge clk or posedge rst)
    if (rst) si_m <= 1'b0;
    else if (icb_wr && hit && (icb_lds || (icb_uds && icb_wdata[13])))
      si_m <= 1'b1;
    else if (loc_rd && loc_addr == LOC_MAILBOX_ADDR) si_m <= 1'b0;
  always_ff @(posedge clk or posedge rst)
    if (rst) lvl_m <= LVL_NONE;
    else if (icb_wr && hit && icb_uds) lvl_m <= icb_wdata[10:8];
  sequence s_loc(a);
    loc_rd && loc_addr == a;
  endsequence
  sequence s_sel_rd;
    icb_rd && hit;
  endsequence
  sequence s_sel_wr;
    icb_wr && hit;
  endsequence
  // ==========================================================
  // Assertions
  a_loc_answer: assert property (
    loc_rd || loc_wr |=> loc_ack == $past(mapped))
    else $error("local answer wrong");
  a_trig_reads_zero: assert property (
    s_loc(LOC_IRQ_TRIG_ADDR) |=> loc_rdata == 8'h00)
    else $error("trigger address readable");
  a_fault_held: assert property (
    fault_stb ##1 !fault_stb ##1 s_loc(LOC_FAULT_ADDR) ##0 !fault_stb
    |=> loc_rdata == {1'b0, $past(fault_flags, 3)})
    else $error("fault cause not held");
  a_icb_answer: assert property (
    icb_rd || icb_wr |=> icb_dtack == $past(hit))
    else $error("slot answer wrong");
  a_status_word: assert property (
    s_sel_rd ##0 icb_uds |=> icb_rdata[15:8] ==
      {$past(si_m), $past(mi_m), BOARD_TYPE, !$past(is_master)})
    else $error("status word wrong");
  a_lane_zero: assert property (
    s_sel_rd ##0 (icb_lds && !icb_uds) |=> icb_rdata[15:8] == 8'h00)
    else $error("unselected lane not zero");
  a_req_line: assert property (
    icb_irq_oe == oe_m && icb_irq_o == 7'h00)
    else $error("request line wrong");
  a_cfg_apply: assert property (
    s_sel_wr ##0 icb_uds |=> main_memory_bus_pri ==
      $past(icb_wdata[12:11]) && slave_reset_n == $past(icb_wdata[15]))
    else $error("config not applied");
  a_slave_level: assert property (
    !is_master && !serial_irq |->
      cpu_ipl == (si_m ? LVL_FROM_MASTER : LVL_NONE))
    else $error("slave level wrong");
endmodule : smbx_top_sva
`default_nettype wire

// File: verif/smbx_icb_master.sv
// Purpose: Bus master model for the slot registers
// Assumes: One-cycle strobes, answer one cycle after the strobe
// Notes:   Released address and data lines show inverted values; lane selects keep theirs
`timescale 1ns/1ps
`default_nettype none
module smbx_icb_master
  import smbx_pkg::*;
#(
  parameter int HOLD_CYC = 1251
)(
  input  wire logic        clk,
  input  wire logic        icb_dtack,
  output var  logic        icb_rd,
  output var  logic        icb_wr,
  output var  logic [23:0] icb_addr,
  output var  logic        icb_uds,
  output var  logic        icb_lds,
  output var  logic [15:0] icb_wdata
);
  initial begin
    {icb_rd, icb_wr, icb_uds, icb_lds} = 4'h0;
    {icb_addr, icb_wdata} = '0;
  end
  task automatic xfer(input logic wr, input logic [3:0] slot,
                      input logic [1:0] ln, input logic [15:0] d);
    int n;
    @(posedge clk);
    icb_rd <= !wr;
    icb_wr <= wr;
    icb_addr <= {ICB_WIN_NIBBLE, slot, SLOT_REG_OFFS};
    {icb_uds, icb_lds} <= ln;
    icb_wdata <= d;
    @(posedge clk);
    icb_rd <= 1'b0;
    icb_wr <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (icb_dtack !== 1'b1 && n < 3);
    icb_addr <= ~icb_addr;
    icb_wdata <= ~icb_wdata;
  endtask : xfer
  // Both lines low for over 10 us at 8 ns before release
  task automatic reset_slave(input logic [3:0] slot,
                             input logic [5:0] lo);
    xfer(1'b1, slot, 2'b10, {2'b00, lo, 8'h00});
    repeat (HOLD_CYC) @(posedge clk);
    xfer(1'b1, slot, 2'b10, {2'b11, lo, 8'h00});
  endtask : reset_slave
endmodule : smbx_icb_master
`default_nettype wire

// File: verif/smbx_top_tb.sv
// Purpose: Self-checking bench for the slave bus mailbox block
// Assumes: Answers come exactly one cycle after each strobe
// Notes:   Answers are checked against a queue of expected notes
`timescale 1ns/1ps
`default_nettype none
module smbx_top_tb;
  import smbx_pkg::*;
  logic        clk, rst, is_master, loc_rd, loc_wr, loc_ack;
  logic        icb_rd, icb_wr, icb_uds, icb_lds, icb_dtack;
  logic        fault_stb, serial_irq, slave_reset_n, slave_halt_n;
  logic [1:0]  main_memory_bus_pri;
  logic [2:0]  cpu_ipl;
  logic [3:0]  slot_id;
  logic [6:0]  fault_flags, f;
  logic [7:0]  loc_wdata, loc_rdata, c, s;
  logic [7:1]  icb_irq_in_n, icb_irq_o, icb_irq_oe;
  logic [15:0] icb_wdata, icb_rdata;
  logic [16:0] e, q[$];
  logic [23:0] loc_addr, icb_addr;
  logic [31:0] seed = 32'h1f44_de7b;
  int          fail_count, checked, cyc;
  smbx_top i_smbx_top (.clk, .rst, .is_master, .slot_id, .loc_rd,
    .loc_wr, .loc_addr, .loc_wdata, .loc_rdata, .loc_ack, .icb_rd,
    .icb_wr, .icb_addr, .icb_uds, .icb_lds, .icb_wdata, .icb_rdata,
    .icb_dtack, .icb_irq_in_n, .icb_irq_o, .icb_irq_oe, .fault_stb,
    .fault_flags, .serial_irq, .cpu_ipl, .slave_reset_n, .slave_halt_n,
    .main_memory_bus_pri);
  smbx_icb_master i_smbx_icb_master (.clk, .icb_dtack, .icb_rd, .icb_wr,
    .icb_addr, .icb_uds, .icb_lds, .icb_wdata);
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic miss(input string m);
    fail_count++;
    $display("MISMATCH t=%0t %s", $time, m);
  endtask : miss
  task automatic cmp(input logic [15:0] g, input logic [15:0] x);
    checked++;
    if (g !== x) miss($sformatf("got %h expected %h", g, x));
  endtask : cmp
  task automatic results();
    if (fail_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  // Note {check, data} queued only where an answer is due
  task automatic loc(input logic wr, input logic [23:0] a,
                     input logic [7:0] d, input logic [16:0] x);
    if (a inside {LOC_MAILBOX_ADDR, LOC_IRQ_TRIG_ADDR, LOC_FAULT_ADDR})
      q.push_back(x);
    @(posedge clk);
    loc_rd <= !wr;
    loc_wr <= wr;
    loc_addr <= a;
    loc_wdata <= d;
    @(posedge clk);
    loc_rd <= 1'b0;
    loc_wr <= 1'b0;
    @(posedge clk);
    loc_addr <= ~a;
    loc_wdata <= ~d;
  endtask : loc
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ==========================================================
  // Answer monitor and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (loc_ack === 1'b1 || icb_dtack === 1'b1) begin
      if (q.size() == 0) miss("answer with none due");
      else begin
        e = q.pop_front();
        if (e[16]) cmp(loc_ack ? 16'(loc_rdata) : icb_rdata, e[15:0]);
      end
    end
    if (cyc > 5000) begin
      miss("timeout");
      results();
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    {rst, is_master, loc_rd, loc_wr, fault_stb, serial_irq} = 6'h20;
    {loc_addr, loc_wdata, fault_flags} = '0;
    icb_irq_in_n = 7'h7F;
    slot_id = 4'h3;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    cmp({2'b00, slave_reset_n, slave_halt_n, main_memory_bus_pri,
         cpu_ipl, icb_irq_oe}, 16'h3000);
    c = 8'(rnd());
    q.push_back(17'h0_0000);
    i_smbx_icb_master.xfer(1'b1, slot_id, 2'b01, {8'h00, c});
    cmp(16'(cpu_ipl), 16'(LVL_FROM_MASTER));
    loc(1'b0, LOC_MAILBOX_ADDR, 8'h00, {9'h100, c});
    cmp(16'(cpu_ipl), 16'(LVL_NONE));
    q.push_back(17'h0_0000);
    i_smbx_icb_master.xfer(1'b1, slot_id, 2'b10, 16'hD300);
    cmp(16'(main_memory_bus_pri), 16'h0002);
    s = 8'(rnd());
    loc(1'b1, LOC_MAILBOX_ADDR, s, 17'h0_0000);
    loc(1'b1, LOC_IRQ_TRIG_ADDR, 8'(rnd()), 17'h0_0000);
    cmp(16'(icb_irq_oe), 16'h0004);
    loc(1'b0, LOC_IRQ_TRIG_ADDR, 8'h00, 17'h1_0000);
    q.push_back({3'b101, BOARD_TYPE, 1'b1, s});
    i_smbx_icb_master.xfer(1'b0, slot_id, 2'b11, 16'h0000);
    cmp(16'(icb_irq_oe), 16'h0000);
    q.push_back({9'h100, s});
    i_smbx_icb_master.xfer(1'b0, slot_id, 2'b01, 16'h0000);
    q.push_back(17'h0_0000);
    i_smbx_icb_master.xfer(1'b1, slot_id, 2'b10, 16'hF300);
    cmp(16'(cpu_ipl), 16'(LVL_FROM_MASTER));
    loc(1'b0, LOC_MAILBOX_ADDR, 8'h00, {9'h100, c});
    loc(1'b0, 24'h4E_0005, 8'h00, 17'h1_0000);
    i_smbx_icb_master.xfer(1'b0, slot_id ^ 4'h1, 2'b11, 16'h0);
    for (int i = 0; i < 8; i++) begin
      f = (i < 7) ? 7'(1 << i) : 7'(rnd());
      @(posedge clk);
      fault_stb <= 1'b1;
      fault_flags <= f;
      @(posedge clk);
      fault_stb <= 1'b0;
      fault_flags <= ~f;
      repeat (2) loc(1'b0, LOC_FAULT_ADDR, 8'h00, {10'h200, f});
    end
    q.push_back(17'h0_0000);
    q.push_back(17'h0_0000);
    fork
      i_smbx_icb_master.reset_slave(slot_id, 6'h13);
      begin
        repeat (20) @(posedge clk);
        cmp({14'h0, slave_reset_n, slave_halt_n}, 16'h0000);
      end
    join
    cmp({14'h0, slave_reset_n, slave_halt_n}, 16'h0003);
    // Mid-run reset must drop both flags, status and fault byte
    q.push_back(17'h0_0000);
    i_smbx_icb_master.xfer(1'b1, slot_id, 2'b01, 16'h00A5);
    loc(1'b1, LOC_IRQ_TRIG_ADDR, 8'(rnd()), 17'h0_0000);
    fault_stb <= 1'b1;
    fault_flags <= 7'h7F;
    @(posedge clk);
    fault_stb <= 1'b0;
    cmp({cpu_ipl, 6'h00, icb_irq_oe}, {LVL_FROM_MASTER, 13'h0004});
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    cmp({cpu_ipl, 6'h00, icb_irq_oe}, 16'h0000);
    q.push_back({3'b100, BOARD_TYPE, 1'b1, STATUS_RESET_VAL});
    i_smbx_icb_master.xfer(1'b0, slot_id, 2'b11, 16'h0000);
    loc(1'b0, LOC_FAULT_ADDR, 8'h00, {9'h100, FAULT_RESET_VAL});
    is_master <= 1'b1;
    for (int l = 1; l < 6; l++) begin
      icb_irq_in_n <= ~(7'(1) << (l - 1));
      @(posedge clk);
      cmp(16'(cpu_ipl), 16'(l));
    end
    icb_irq_in_n <= 7'h7F;
    serial_irq <= 1'b1;
    @(posedge clk);
    cmp(16'(cpu_ipl), 16'(LVL_SERIAL));
    q.push_back({3'b100, BOARD_TYPE, 1'b0, 8'h00});
    i_smbx_icb_master.xfer(1'b0, slot_id, 2'b10, 16'h0000);
    repeat (2) @(posedge clk);
    if (q.size() != 0) miss("answer never came");
    results();
  end
endmodule : smbx_top_tb
bind smbx_top smbx_top_sva i_smbx_top_sva (.clk, .rst, .is_master,
  .slot_id, .loc_rd, .loc_wr, .loc_addr, .loc_rdata, .loc_ack, .icb_rd,
  .icb_wr, .icb_addr, .icb_uds, .icb_lds, .icb_wdata, .icb_rdata,
  .icb_dtack, .icb_irq_o, .icb_irq_oe, .fault_stb, .fault_flags,
  .serial_irq, .cpu_ipl, .slave_reset_n, .main_memory_bus_pri);
`default_nettype wire
